// File: pkg/fsps_pkg.sv
// Behaviour
// R01 - Reset fetch address is 0x0000 with fuse at 1, boot loader address with 0.
// R02 - Software has no write path to the boot vector fuse.
// R03 - Pointer low bits pick the word in a page, high bits pick the page.
// R04 - Target page is latched when an operation starts; later pointer changes are ignored.
// R05 - Program byte reads use pointer bit 0 to pick the byte of a word.
// R06 - Software erases a page before writing it; buffer fill may precede or follow erase.
// R07 - Page buffer accepts word loads in any order.
// R08 - Pattern X0000011 then store within four clocks erases the pointer's page.
// R09 - Pattern 00000001 then store within four clocks loads data word into buffer.
// R10 - Buffer clears after page write, on region re-enable, and on reset.
// R11 - Software loads each buffer word at most once between buffer clears.
// R12 - An EEPROM write during page loading discards all loaded words.
// R13 - Pattern X0000101 then store within four clocks writes the pointer's page.
// R14 - Operations on the halt-on-write region stall the processor until done.
// R15 - Enabled completion interrupt stays high while the enable bit is clear.
// R16 - During erase or write the region is blocked and busy flag reads set.
// R17 - Busy flag stays set after completion until region re-enable command.
// R18 - Pattern X0001001 then store programs lock bits where data bits 5..0 are zero.
// R19 - Software should load pointer 0x0001 and data bits 7..6 high for lock writes.
// R20 - Lock bit programming leaves the whole flash readable.
// R21 - An active EEPROM write blocks every programming command.
// R22 - Software should wait for EEPROM write idle before writing the control register.
// R23 - Software gives erase and write of one update the same page address.
// R24 - Command and enable bits self-clear when no store follows within four cycles.
// R25 - Each erase, write or lock operation lasts between 3.7 ms and 4.5 ms.
// R26 - Enable bit stays set during an accepted operation and clears when it ends.
package fsps_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;

  // Register offsets
  localparam logic [ADDR_W-1:0] REG_CTRL      = 4'h0;
  localparam logic [ADDR_W-1:0] REG_PTR_LO    = 4'h1;
  localparam logic [ADDR_W-1:0] REG_PTR_HI    = 4'h2;
  localparam logic [ADDR_W-1:0] REG_DAT_LO    = 4'h3;
  localparam logic [ADDR_W-1:0] REG_DAT_HI    = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STORE     = 4'h5;
  localparam logic [ADDR_W-1:0] REG_PROG_BYTE = 4'h6;
  localparam logic [ADDR_W-1:0] REG_BUF_BYTE  = 4'h7;

  // Control register fields
  localparam int CTRL_EN   = 0;
  localparam int CTRL_BUSY = 6;
  localparam int CTRL_IE   = 7;
  localparam int CMD_W     = 5;

  // Command patterns on control bits 4..0
  localparam logic [CMD_W-1:0] CMD_LOAD  = 5'h01;
  localparam logic [CMD_W-1:0] CMD_ERASE = 5'h03;
  localparam logic [CMD_W-1:0] CMD_WRITE = 5'h05;
  localparam logic [CMD_W-1:0] CMD_LOCK  = 5'h09;
  localparam logic [CMD_W-1:0] CMD_REEN  = 5'h11;

  localparam logic [2:0] STORE_WINDOW = 3'h4;

  // Programming time
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_MIN_NS   = 3700000;
  localparam int PROG_MAX_NS   = 4500000;
  localparam int PROG_MIN_CYC  = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_MAX_CYC  = PROG_MAX_NS / CLK_PERIOD_NS;

  localparam logic [15:0] APP_RESET_ADDR = 16'h0000;
  localparam logic [15:0] ERASED_WORD    = 16'hffff;
  localparam int          LOCK_W         = 6;
  localparam logic [5:0]  LOCK_RESET     = 6'h3f;

  // Operation kind shown on o_prog_kind
  localparam logic [1:0] KIND_NONE  = 2'h0;
  localparam logic [1:0] KIND_ERASE = 2'h1;
  localparam logic [1:0] KIND_WRITE = 2'h2;
  localparam logic [1:0] KIND_LOCK  = 2'h3;

  typedef enum logic [0:0] {FSPS_IDLE, FSPS_BUSY} fsps_state_e;

  // Pick one byte of a flash word
  function automatic logic [7:0] fsps_byte_sel(input logic [15:0] w, input logic hi);
    fsps_byte_sel = hi ? w[15:8] : w[7:0];
  endfunction : fsps_byte_sel

endpackage : fsps_pkg

// File: pkg/fsps_buf_if.sv
`timescale 1ns/100ps
`default_nettype none
interface fsps_buf_if #(parameter int WORD_BITS = 7);
  logic                 we;
  logic [WORD_BITS-1:0] widx;
  logic [15:0]          wdata;
  logic                 clr;
  logic [WORD_BITS-1:0] ridx;
  logic [15:0]          rdata;
  logic                 any_loaded;
  modport ctrl (output we, widx, wdata, clr, ridx, input rdata, any_loaded);
  modport mem  (input we, widx, wdata, clr, ridx, output rdata, any_loaded);
endinterface : fsps_buf_if
`default_nettype wire

// File: hw/fsps_page_buffer.sv
`timescale 1ns/100ps
`default_nettype none
module fsps_page_buffer #(
  parameter int WORD_BITS = 7
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  fsps_buf_if.mem  bus
);
  import fsps_pkg::*;

  logic [15:0]              mem [2**WORD_BITS];
  logic [2**WORD_BITS-1:0]  loaded;

  // Per-word loaded marks; clearing them empties the buffer at once
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      loaded <= '0; // R10
    end else if (bus.clr) begin
      loaded <= '0; // R10
    end else if (bus.we) begin
      loaded[bus.widx] <= 1'b1; // R07
    end
  end

  // Any word index may be written at any time
  always_ff @(posedge i_ref_clk) begin
    if (bus.we) begin
      mem[bus.widx] <= bus.wdata; // R07
    end
  end

  // Unloaded words read as erased, so no data array reset is needed
  assign bus.rdata      = loaded[bus.ridx] ? mem[bus.ridx] : ERASED_WORD;
  assign bus.any_loaded = |loaded;

endmodule : fsps_page_buffer
`default_nettype wire

// File: hw/fsps_op_timer.sv
`timescale 1ns/100ps
`default_nettype none
module fsps_op_timer #(
  parameter int CYCLES = fsps_pkg::PROG_MIN_CYC
) (
  input  wire logic i_ref_clk,
  input  wire logic i_nrst,
  input  wire logic i_start,
  output logic      o_done
);
  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt;

  // Down counter; done pulses in the last counted cycle
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt <= '0;
    end else if (i_start) begin
      cnt <= CW'(CYCLES); // R25
    end else if (cnt != '0) begin
      cnt <= cnt - CW'(1);
    end
  end

  assign o_done = (cnt == CW'(1));

endmodule : fsps_op_timer
`default_nettype wire

// File: hw/fsps_sequencer.sv
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module fsps_sequencer #(
  parameter int          WORD_BITS       = 7,
  parameter int          PROG_CYCLES     = fsps_pkg::PROG_MIN_CYC,
  parameter logic [15:0] BOOT_RESET_ADDR = 16'hf000,
  parameter logic [7:0]  HALT_ON_WRITE_REGION_FIRST_PAGE = 8'he0
) (
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_nrst,
  input  wire logic [fsps_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [fsps_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic      [fsps_pkg::DATA_W-1:0] o_rdata,
  input  wire logic                        i_boot_vector_select_fuse,
  input  wire logic                        i_eeprom_write_active_flag,
  input  wire logic [15:0]                 i_flash_rword,
  output logic      [14:0]                 o_flash_raddr,
  output logic      [15:0]                 o_reset_vector,
  output logic                             o_reset_vector_valid,
  output logic                             o_irq,
  output logic                             o_cpu_halt,
  output logic                             o_rww_blocked,
  output logic                             o_prog_start,
  output logic      [1:0]                  o_prog_kind,
  output logic      [14-WORD_BITS:0]       o_prog_page,
  output logic      [fsps_pkg::LOCK_W-1:0] o_lock_bits
);
  import fsps_pkg::*;

  localparam int PAGE_W = 15 - WORD_BITS;

  fsps_buf_if #(.WORD_BITS(WORD_BITS)) buf_bus ();

  fsps_state_e state;

  logic [7:0]           pointer_low_byte;
  logic [7:0]           pointer_high_byte;
  logic [7:0]           data_low_reg;
  logic [7:0]           data_high_reg;
  logic [CMD_W-1:0]     cmd_bits;
  logic                 irq_enable;
  logic                 region_busy_flag;
  logic [2:0]           store_window;
  logic                 vector_taken;
  logic                 op_done;

  logic [15:0]          pointer;
  logic [PAGE_W-1:0]    page_index_field;
  logic [WORD_BITS-1:0] word_in_page_field;
  logic                 selfprog_enable_bit;
  logic                 ctrl_write;
  logic                 store_op;
  logic                 store_ok;
  logic                 go_load;
  logic                 go_erase;
  logic                 go_write;
  logic                 go_lock;
  logic                 go_reen;
  logic                 go_prog;
  logic [7:0]           ctrl_view;

  // Pointer fields: byte bit 0, word field, then page field
  assign pointer            = {pointer_high_byte, pointer_low_byte};
  assign word_in_page_field = pointer[WORD_BITS:1]; // R03
  assign page_index_field   = pointer[15:WORD_BITS+1]; // R03

  assign selfprog_enable_bit = cmd_bits[CTRL_EN];

  // Store is only honoured inside the window after a control write
  assign ctrl_write = i_wr && (i_addr == REG_CTRL);
  assign store_op   = i_wr && (i_addr == REG_STORE);
  assign store_ok   = store_op && (store_window != 3'h0) && (state == FSPS_IDLE)
                      && !i_eeprom_write_active_flag; // R21

  // Command decode from the armed control pattern
  assign go_load  = store_ok && (cmd_bits == CMD_LOAD); // R09
  assign go_erase = store_ok && (cmd_bits == CMD_ERASE); // R08
  assign go_write = store_ok && (cmd_bits == CMD_WRITE); // R13
  assign go_lock  = store_ok && (cmd_bits == CMD_LOCK); // R18
  assign go_reen  = store_ok && (cmd_bits == CMD_REEN);
  assign go_prog  = go_erase || go_write || go_lock;

  // Busy flag lives in bit 6; bit 5 reads zero
  assign ctrl_view = {irq_enable, region_busy_flag, 1'b0, cmd_bits};

  fsps_page_buffer #(
    .WORD_BITS (WORD_BITS)
  ) u_page_buffer (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .bus       (buf_bus)
  );

  fsps_op_timer #(
    .CYCLES    (PROG_CYCLES)
  ) u_op_timer (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_start   (go_prog),
    .o_done    (op_done)
  );

  // Buffer port: word field picks the slot, data pair is the word
  assign buf_bus.we    = go_load && !i_eeprom_write_active_flag;
  assign buf_bus.widx  = word_in_page_field; // R07
  assign buf_bus.wdata = {data_high_reg, data_low_reg}; // R09
  assign buf_bus.ridx  = word_in_page_field;

  // Clear after page write, on re-enable, or when EEPROM write hits loading
  assign buf_bus.clr = (op_done && (o_prog_kind == KIND_WRITE)) // R10
                       || go_reen // R10
                       || (i_eeprom_write_active_flag && buf_bus.any_loaded); // R12

  // Boot vector is taken once after reset release; fuse is input only
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      vector_taken         <= 1'b0;
      o_reset_vector       <= APP_RESET_ADDR;
      o_reset_vector_valid <= 1'b0;
    end else if (!vector_taken) begin
      vector_taken         <= 1'b1;
      o_reset_vector_valid <= 1'b1;
      o_reset_vector       <= i_boot_vector_select_fuse ? APP_RESET_ADDR
                                                        : BOOT_RESET_ADDR; // R01 R02
    end
  end

  // Pointer and data pair, plain software storage
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pointer_low_byte  <= 8'h00;
      pointer_high_byte <= 8'h00;
      data_low_reg      <= 8'h00;
      data_high_reg     <= 8'h00;
    end else if (i_wr) begin
      case (i_addr)
        REG_PTR_LO: begin
          pointer_low_byte <= i_wdata;
        end
        REG_PTR_HI: begin
          pointer_high_byte <= i_wdata;
        end
        REG_DAT_LO: begin
          data_low_reg <= i_wdata;
        end
        REG_DAT_HI: begin
          data_high_reg <= i_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // Store window counts down from each accepted control write
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      store_window <= 3'h0;
    end else if (ctrl_write && (state == FSPS_IDLE) && !i_eeprom_write_active_flag) begin
      store_window <= STORE_WINDOW; // R24
    end else if (store_op || (store_window == 3'h0)) begin
      store_window <= 3'h0;
    end else begin
      store_window <= store_window - 3'h1;
    end
  end

  // Command and enable bits: armed by writes, dropped on timeout, on finish or on a store that starts no operation
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cmd_bits <= '0;
    end else if (state == FSPS_BUSY) begin
      if (op_done) begin
        cmd_bits <= '0; // R26
      end
    end else if (ctrl_write && !i_eeprom_write_active_flag) begin
      cmd_bits <= i_wdata[CMD_W-1:0]; // R21
    end else if (go_prog) begin
      cmd_bits <= cmd_bits; // R26
    end else if (store_op) begin
      cmd_bits <= '0;
    end else if (store_window == 3'h1) begin
      cmd_bits <= '0; // R24
    end
  end

  // Interrupt enable is plain storage, writable even while busy
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_enable <= 1'b0;
    end else if (ctrl_write) begin
      irq_enable <= i_wdata[CTRL_IE];
    end
  end

  // Sequencer state: idle or one timed flash operation
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= FSPS_IDLE;
    end else begin
      case (state)
        FSPS_IDLE: begin
          if (go_prog) begin
            state <= FSPS_BUSY;
          end
        end
        FSPS_BUSY: begin
          if (op_done) begin
            state <= FSPS_IDLE; // R25
          end
        end
        default: begin
          state <= FSPS_IDLE;
        end
      endcase
    end
  end

  // Target page and kind latched at start so the pointer is free again
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_prog_page <= '0;
      o_prog_kind <= KIND_NONE;
    end else if (go_erase || go_write) begin
      o_prog_page <= page_index_field; // R04
      o_prog_kind <= go_erase ? KIND_ERASE : KIND_WRITE;
    end else if (go_lock) begin
      o_prog_kind <= KIND_LOCK; // R18
    end else if (op_done) begin
      o_prog_kind <= KIND_NONE;
    end
  end

  // Start pulse to the flash array, one cycle
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_prog_start <= 1'b0;
    end else begin
      o_prog_start <= go_prog;
    end
  end

  // Lock bits only go from one to zero; pointer is ignored here
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_lock_bits <= LOCK_RESET;
    end else if (go_lock) begin
      o_lock_bits <= o_lock_bits & data_low_reg[LOCK_W-1:0]; // R18
    end
  end

  // Region busy from erase or write start until the re-enable command
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      region_busy_flag <= 1'b0;
    end else if (go_erase || go_write) begin
      region_busy_flag <= 1'b1; // R16
    end else if (go_reen) begin
      region_busy_flag <= 1'b0; // R17
    end
  end

  // Reads are blocked only while erase or write runs, never for lock bits
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rww_blocked <= 1'b0;
    end else if (go_erase || go_write) begin
      o_rww_blocked <= 1'b1; // R16
    end else if (op_done || go_lock) begin
      o_rww_blocked <= 1'b0; // R20
    end
  end

  // Halt the core when the target page is in the halt-on-write region
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cpu_halt <= 1'b0;
    end else if (go_erase || go_write) begin
      o_cpu_halt <= (page_index_field >= HALT_ON_WRITE_REGION_FIRST_PAGE[PAGE_W-1:0]); // R14
    end else if (op_done) begin
      o_cpu_halt <= 1'b0; // R14
    end
  end

  // Level interrupt while enabled and the enable bit is clear
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= irq_enable && !selfprog_enable_bit; // R15
    end
  end

  // Flash word address for byte reads tracks the pointer
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_flash_raddr <= '0;
    end else begin
      o_flash_raddr <= pointer[15:1];
    end
  end

  // Read data in the cycle after the strobe; unmapped reads return zero
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      case (i_addr)
        REG_CTRL: begin
          o_rdata <= ctrl_view;
        end
        REG_PTR_LO: begin
          o_rdata <= pointer_low_byte;
        end
        REG_PTR_HI: begin
          o_rdata <= pointer_high_byte;
        end
        REG_DAT_LO: begin
          o_rdata <= data_low_reg;
        end
        REG_DAT_HI: begin
          o_rdata <= data_high_reg;
        end
        REG_PROG_BYTE: begin
          o_rdata <= fsps_byte_sel(i_flash_rword, pointer[0]); // R05
        end
        REG_BUF_BYTE: begin
          o_rdata <= fsps_byte_sel(buf_bus.rdata, pointer[0]);
        end
        default: begin
          o_rdata <= '0;
        end
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

endmodule : fsps_sequencer
`default_nettype wire

// File: verification/fsps_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module fsps_monitor #(
  parameter int          WORD_BITS       = 7,
  parameter int          PROG_CYCLES     = 20,
  parameter logic [15:0] BOOT_RESET_ADDR = 16'hf000,
  parameter logic [7:0]  HALT_ON_WRITE_REGION_FIRST_PAGE = 8'he0
) (
  input wire logic                        i_ref_clk,
  input wire logic                        i_nrst,
  input wire logic [fsps_pkg::ADDR_W-1:0] i_addr,
  input wire logic                        i_wr,
  input wire logic                        i_boot_vector_select_fuse,
  input wire logic                        i_eeprom_write_active_flag,
  input wire logic [15:0]                 o_reset_vector,
  input wire logic                        o_reset_vector_valid,
  input wire logic                        o_irq,
  input wire logic                        o_cpu_halt,
  input wire logic                        o_rww_blocked,
  input wire logic                        o_prog_start,
  input wire logic [1:0]                  o_prog_kind,
  input wire logic [14-WORD_BITS:0]       o_prog_page,
  input wire logic [fsps_pkg::LOCK_W-1:0] o_lock_bits
);
  import fsps_pkg::*;
  logic [31:0] run_len;
  // Cycles spent in the current operation; a stuck timer shows as a wrong count
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      run_len <= '0;
    end else begin
      run_len <= (o_prog_kind != KIND_NONE) ? run_len + 32'h1 : '0;
    end
  end
  default clocking mon_cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  // Operation timing, blocking and vector checks
  op_length_a: assert property ((o_prog_kind == KIND_NONE && $past(o_prog_kind) != KIND_NONE)
    |-> run_len == PROG_CYCLES) else $error("operation length wrong");
  start_pulse_a: assert property (o_prog_start |-> o_prog_kind != KIND_NONE
    && $past(o_prog_kind) == KIND_NONE ##1 !o_prog_start) else $error("start pulse wrong");
  irq_quiet_a: assert property (o_prog_kind != KIND_NONE |=> !o_irq)
    else $error("irq high during operation");
  blocked_kind_a: assert property (o_rww_blocked ==
    (o_prog_kind == KIND_ERASE || o_prog_kind == KIND_WRITE)) else $error("region block wrong");
  halt_page_a: assert property (o_cpu_halt ==
    (o_rww_blocked && o_prog_page >= HALT_ON_WRITE_REGION_FIRST_PAGE)) else $error("halt wrong");
  lock_clear_a: assert property ((o_lock_bits & ~$past(o_lock_bits)) == '0)
    else $error("lock bit set back");
  lock_cause_a: assert property (o_lock_bits != $past(o_lock_bits)
    |-> o_prog_start && o_prog_kind == KIND_LOCK) else $error("lock change without op");
  eeprom_block_a: assert property (i_eeprom_write_active_flag && i_wr && i_addr == REG_STORE
    |=> !o_prog_start) else $error("store taken during eeprom write");
  vector_pick_a: assert property ($rose(o_reset_vector_valid) |-> o_reset_vector ==
    ($past(i_boot_vector_select_fuse) ? APP_RESET_ADDR : BOOT_RESET_ADDR))
    else $error("reset vector wrong");
  vector_hold_a: assert property (o_reset_vector_valid && $past(o_reset_vector_valid)
    |-> $stable(o_reset_vector)) else $error("reset vector moved");
  // Main scenarios reached
  cover property (o_prog_start && o_prog_kind == KIND_ERASE);
  cover property (o_prog_start && o_prog_kind == KIND_WRITE);
  cover property (o_prog_start && o_prog_kind == KIND_LOCK);
  cover property (o_cpu_halt);
endmodule : fsps_monitor
bind fsps_sequencer fsps_monitor #(.WORD_BITS(WORD_BITS), .PROG_CYCLES(PROG_CYCLES),
  .BOOT_RESET_ADDR(BOOT_RESET_ADDR), .HALT_ON_WRITE_REGION_FIRST_PAGE(HALT_ON_WRITE_REGION_FIRST_PAGE)) fsps_monitor_inst (
  .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wr(i_wr),
  .i_boot_vector_select_fuse(i_boot_vector_select_fuse),
  .i_eeprom_write_active_flag(i_eeprom_write_active_flag), .o_reset_vector(o_reset_vector),
  .o_reset_vector_valid(o_reset_vector_valid), .o_irq(o_irq), .o_cpu_halt(o_cpu_halt),
  .o_rww_blocked(o_rww_blocked), .o_prog_start(o_prog_start), .o_prog_kind(o_prog_kind),
  .o_prog_page(o_prog_page), .o_lock_bits(o_lock_bits));
`default_nettype wire

// File: verification/fsps_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module fsps_flash_model (
  input  wire logic [14:0] i_addr,
  output logic      [15:0] o_word
);
  // Every word differs from its neighbours, so a wrong address shows at once
  assign o_word = {1'b0, i_addr} ^ 16'ha5c3;
endmodule : fsps_flash_model
`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import fsps_pkg::*;
  localparam int PC = 20;
  logic        ref_clk = 1'b0;
  logic        nrst    = 1'b0;
  logic [3:0]  addr    = 4'h0;
  logic [7:0]  wdata   = 8'h00;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic        fuse    = 1'b1;
  logic        ee      = 1'b0;
  logic [7:0]  rdata;
  logic [15:0] fword;
  logic [14:0] fraddr;
  logic [15:0] rvec;
  logic        rvec_ok;
  logic        irq;
  logic        halt;
  logic        blocked;
  logic        pstart;
  logic [1:0]  kind;
  logic [7:0]  page;
  logic [5:0]  lock;
  int          bad_count    = 0;
  int          total_checks = 0;
  int          cycles       = 0;
  fsps_sequencer #(.PROG_CYCLES(PC), .BOOT_RESET_ADDR(16'hf000)) fsps_sequencer_inst (
    .i_ref_clk(ref_clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_boot_vector_select_fuse(fuse),
    .i_eeprom_write_active_flag(ee), .i_flash_rword(fword), .o_flash_raddr(fraddr),
    .o_reset_vector(rvec), .o_reset_vector_valid(rvec_ok), .o_irq(irq), .o_cpu_halt(halt),
    .o_rww_blocked(blocked), .o_prog_start(pstart), .o_prog_kind(kind),
    .o_prog_page(page), .o_lock_bits(lock));
  fsps_flash_model fsps_flash_model_inst (.i_addr(fraddr), .o_word(fword));
  // Free-running clock and hang guard
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Bus access: one strobe cycle, then the strobe drops at the next edge
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e,
                        input string n);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    @(posedge ref_clk); // Data launched by the strobe edge still stands here
    chk(n, 16'(e), 16'(rdata & m));
  endtask : rd_chk
  task automatic set_ptr(input logic [15:0] p);
    wr_reg(REG_PTR_LO, p[7:0]);
    wr_reg(REG_PTR_HI, p[15:8]);
  endtask : set_ptr
  // Control write, store inside the window, then one edge so results have landed
  task automatic spm(input logic [7:0] c);
    wr_reg(REG_CTRL, c);
    wr_reg(REG_STORE, 8'h00);
    @(posedge ref_clk);
  endtask : spm
  task automatic load(input logic [15:0] p, input logic [15:0] w);
    set_ptr(p);
    wr_reg(REG_DAT_LO, w[7:0]);
    wr_reg(REG_DAT_HI, w[15:8]);
    spm(8'h81);
  endtask : load
  task automatic peek(input logic [15:0] p, input logic [7:0] e);
    set_ptr(p);
    rd_chk(REG_BUF_BYTE, 8'hff, e, "buffer byte");
  endtask : peek
  task automatic wait_idle;
    int n;
    n = 0;
    while (kind !== KIND_NONE && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    chk("operation end", 16'(KIND_NONE), 16'(kind));
  endtask : wait_idle
  task automatic do_reset(input logic f);
    fuse <= f;
    nrst <= 1'b0;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("reset vector", f ? 16'h0000 : 16'hf000, rvec);
    chk("vector valid", 16'h1, 16'(rvec_ok));
    chk("lock bits", 16'h3f, 16'(lock));
  endtask : do_reset
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    do_reset(1'b1);
    wr_reg(REG_CTRL, 8'h83);
    repeat (6) @(posedge ref_clk);
    rd_chk(REG_CTRL, 8'hff, 8'h80, "lapsed control");
    chk("irq idle", 16'h1, 16'(irq));
    wr_reg(4'h9, 8'h5a);
    rd_chk(4'h9, 8'hff, 8'h00, "unmapped");
    $display("test window done");
    load(16'h0104, 16'h1234);
    load(16'h0100, 16'h5678);
    peek(16'h0105, 8'h12);
    peek(16'h0100, 8'h78);
    peek(16'h0102, 8'hff);
    set_ptr(16'h1235);
    rd_chk(REG_PROG_BYTE, 8'hff, 8'hac, "program byte");
    $display("test load done");
    ee <= 1'b1;
    repeat (2) @(posedge ref_clk);
    ee <= 1'b0;
    peek(16'h0104, 8'hff);
    ee <= 1'b1;
    spm(8'h83);
    chk("eeprom blocks", 16'(KIND_NONE), 16'(kind));
    ee <= 1'b0;
    $display("test eeprom done");
    load(16'h0100, 16'hbeef);
    set_ptr(16'h1042);
    spm(8'h83);
    set_ptr(16'h2000);
    chk("erase page", 16'h10, 16'(page));
    chk("erase block", 16'h1, 16'(blocked));
    chk("erase halt", 16'h0, 16'(halt));
    rd_chk(REG_CTRL, 8'hc1, 8'hc1, "control in erase");
    wait_idle();
    rd_chk(REG_CTRL, 8'hc1, 8'hc0, "busy after erase");
    chk("irq after erase", 16'h1, 16'(irq));
    spm(8'h91);
    rd_chk(REG_CTRL, 8'hc1, 8'h80, "busy cleared");
    peek(16'h0100, 8'hff);
    $display("test erase done");
    load(16'h0002, 16'h1111);
    set_ptr(16'he000);
    spm(8'h83);
    wait_idle();
    spm(8'h85);
    chk("write kind", 16'(KIND_WRITE), 16'(kind));
    chk("write halt", 16'h1, 16'(halt));
    chk("write page", 16'he0, 16'(page));
    wait_idle();
    peek(16'h0002, 8'hff);
    spm(8'h91);
    $display("test write done");
    set_ptr(16'h0001);
    wr_reg(REG_DAT_LO, 8'hf2);
    spm(8'h89);
    chk("lock bits", 16'h32, 16'(lock));
    chk("lock no block", 16'h0, 16'({blocked, halt}));
    wait_idle();
    wr_reg(REG_DAT_LO, 8'hfd);
    spm(8'h89);
    chk("lock only clear", 16'h30, 16'(lock));
    wait_idle();
    $display("test lock done");
    load(16'h0006, 16'h4321);
    peek(16'h0006, 8'h21);
    do_reset(1'b0);
    peek(16'h0006, 8'hff);
    $display("test boot vector done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
